/* File: hw/cwm_consts.svh */
// Constants for the counter waveform mode block
`ifndef CWM_CONSTS_SVH
`define CWM_CONSTS_SVH
`define CWM_MODE_NORMAL 3'h0
`define CWM_MODE_PC_FF 3'h1
`define CWM_MODE_CTC 3'h2
`define CWM_MODE_FAST_FF 3'h3
`define CWM_MODE_PC_OCA 3'h5
`define CWM_MODE_FAST_OCA 3'h7
`define CWM_ACT_NONE 2'h0
`define CWM_ACT_TOGGLE 2'h1
`define CWM_ACT_CLEAR 2'h2
`define CWM_ACT_SET 2'h3
`define CWM_MAX 8'hff
`define CWM_BOTTOM 8'h00
`define CWM_RST_COUNT 8'h00
`define CWM_RST_COMPARE 8'h00
`endif

/* File: hw/cwm_pkg.sv */
// Types shared by the counter waveform mode block
package cwm_pkg;
    // Broad class of the selected waveform mode
    typedef enum logic [1:0]
    {
        CWM_CLASS_NONPWM = 2'b00,
        CWM_CLASS_FAST = 2'b01,
        CWM_CLASS_PHASE = 2'b10
    } cwm_class_t;
endpackage

/* File: hw/cwm_flag.sv */
// Sticky event flag with write-one clear, where a set wins over a clear
`timescale 1ns/100ps
module cwm_flag
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic set_pulse,
    input wire logic clear_pulse,
    output logic flag
);
    // Next flag value: set has priority over clear
    logic flag_next;
    assign flag_next = set_pulse | (flag & ~clear_pulse);

    // Flag register
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            flag <= 1'b0;
        else
            flag <= flag_next;
    end
endmodule

/* File: hw/cwm_buffer.sv */
// Compare value holder, direct or double buffered
`timescale 1ns/100ps
`include "cwm_consts.svh"
module cwm_buffer
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic buffered,
    input wire logic load_point,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    output logic [7:0] active_value
);
    // Value written by software, waiting for the update point
    logic [7:0] shadow_reg;
    logic [7:0] shadow_next;
    logic [7:0] active_next;

    // Direct mode passes writes straight through
    assign shadow_next = wr_en ? wr_data : shadow_reg;
    assign active_next = !buffered ? shadow_next :
                         (load_point ? shadow_reg : active_value);

    // Shadow and active registers
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            shadow_reg <= `CWM_RST_COMPARE;
            active_value <= `CWM_RST_COMPARE;
        end
        else
        begin
            shadow_reg <= shadow_next;
            active_value <= active_next;
        end
    end
endmodule

/* File: hw/cwm_timer.sv */
// 8-bit timer/counter with CTC, fast PWM and phase correct PWM generation
`timescale 1ns/100ps
`include "cwm_consts.svh"
module cwm_timer
    import cwm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic timer_tick,
    input wire logic [2:0] waveform_mode_select,
    input wire logic [1:0] output_action_select_a,
    input wire logic compare_a_wr,
    input wire logic [7:0] compare_a_wr_data,
    input wire logic count_wr,
    input wire logic [7:0] count_wr_data,
    input wire logic overflow_flag_clear,
    input wire logic compare_a_match_flag_clear,
    input wire logic pin_dir_out,
    input wire logic port_data,
    output logic [7:0] timer_count_value,
    output logic [7:0] compare_a_value,
    output logic overflow_flag,
    output logic compare_a_match_flag,
    output logic waveform_output_a,
    output logic pin_out,
    output logic pin_oe
);
    // Count, direction, internal output state and match pipeline
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic down_reg;
    logic down_next;
    logic wave_reg;
    logic wave_next;
    logic match_dly_reg;
    logic match_dly_next;
    logic block_reg;
    logic block_next;
    logic pin_out_reg;
    logic pin_out_next;
    logic pin_oe_reg;
    logic pin_oe_next;
    logic overflow_flag_w;
    logic match_flag_w;
    logic [7:0] cmp_active;

    // Mode decode
    cwm_class_t mode_class;
    logic mode_fast;
    logic mode_phase;
    logic mode_ctc;
    logic top_is_a;
    logic [7:0] top_value;
    assign mode_fast = (waveform_mode_select == `CWM_MODE_FAST_FF) |
                       (waveform_mode_select == `CWM_MODE_FAST_OCA);
    assign mode_phase = (waveform_mode_select == `CWM_MODE_PC_FF) |
                        (waveform_mode_select == `CWM_MODE_PC_OCA);
    assign mode_ctc = (waveform_mode_select == `CWM_MODE_CTC);
    assign mode_class = mode_fast ? CWM_CLASS_FAST :
                        (mode_phase ? CWM_CLASS_PHASE : CWM_CLASS_NONPWM);
    assign top_is_a = (waveform_mode_select == `CWM_MODE_FAST_OCA) |
                      (waveform_mode_select == `CWM_MODE_PC_OCA);
    assign top_value = top_is_a ? cmp_active : `CWM_MAX;

    // Compare update points: top in fast PWM, top in phase correct
    logic pwm_mode;
    logic at_top;
    logic at_bottom;
    logic load_point;
    assign pwm_mode = (mode_class != CWM_CLASS_NONPWM);
    assign at_top = (count_reg == top_value);
    assign at_bottom = (count_reg == `CWM_BOTTOM);
    assign load_point = timer_tick & at_top;

    // Compare A holder, direct outside PWM modes
    cwm_buffer u_cmp_a
    (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .buffered(pwm_mode),
        .load_point(load_point),
        .wr_en(compare_a_wr),
        .wr_data(compare_a_wr_data),
        .active_value(cmp_active)
    );

    // Match detection, blocked one tick after a count write
    logic match_now;
    assign match_now = (count_reg == cmp_active) & ~block_reg;

    // Counting sequence per mode
    logic [7:0] count_step;
    logic down_step;
    always_comb
    begin
        count_step = count_reg + 8'h01;                                  // wraps via 0xFF
        down_step = 1'b0;
        unique case (mode_class)
            CWM_CLASS_FAST:
            begin
                if (at_top)
                    count_step = `CWM_BOTTOM;
            end
            CWM_CLASS_PHASE:
            begin
                // Turn at top and bottom; top held exactly one tick
                if (!down_reg && at_top)
                begin
                    down_step = 1'b1;
                    count_step = count_reg - 8'h01;
                end
                else if (down_reg && at_bottom)
                    count_step = count_reg + 8'h01;
                else if (down_reg)
                begin
                    down_step = 1'b1;
                    count_step = count_reg - 8'h01;
                end
            end
            CWM_CLASS_NONPWM:
            begin
                if (mode_ctc && match_now)
                    count_step = `CWM_BOTTOM;
            end
        endcase
    end

    // Tick gating and software count writes
    assign count_next = count_wr ? count_wr_data :
                        (timer_tick ? count_step : count_reg);
    assign down_next = timer_tick ? (mode_phase & down_step) : down_reg;
    assign block_next = count_wr ? 1'b1 : (timer_tick ? 1'b0 : block_reg);

    // Waveform action per mode and action select
    logic act_match;
    logic phase_fix;
    logic up_phase;
    always_comb
    begin
        wave_next = wave_reg;
        act_match = timer_tick & match_now;
        // A match at bottom acts as a rising match, one at top as a falling match
        up_phase = down_reg ? at_bottom : !at_top;
        // Above compare at top or while falling, the output must carry the
        // up-match level; force it when that match was missed or compare left MAX
        phase_fix = timer_tick & (down_reg | at_top) & (count_reg > cmp_active);
        if (output_action_select_a == `CWM_ACT_NONE)
            wave_next = wave_reg;
        else if (mode_class == CWM_CLASS_NONPWM)
        begin
            if (act_match)
            begin
                unique case (output_action_select_a)
                    `CWM_ACT_TOGGLE: wave_next = ~wave_reg;
                    `CWM_ACT_CLEAR: wave_next = 1'b0;
                    `CWM_ACT_SET: wave_next = 1'b1;
                    default: wave_next = wave_reg;
                endcase
            end
        end
        else if (mode_class == CWM_CLASS_FAST)
        begin
            if (output_action_select_a == `CWM_ACT_TOGGLE)
            begin
                if (act_match)
                    wave_next = ~wave_reg;
            end
            else if (act_match && !(cmp_active == `CWM_MAX))
                wave_next = output_action_select_a[0];
            else if (timer_tick && at_top)
                // Opposite of the match level at bottom (set for clear, clear for set); compare at MAX keeps a constant level
                wave_next = (cmp_active == `CWM_MAX) ? output_action_select_a[0] :
                            ~output_action_select_a[0];
        end
        else
        begin
            if (output_action_select_a != `CWM_ACT_TOGGLE)
            begin
                if (act_match && up_phase)
                    wave_next = output_action_select_a[0];
                else if (act_match)
                    wave_next = ~output_action_select_a[0];
                else if (phase_fix)
                    wave_next = output_action_select_a[0];
            end
            else if (act_match)
                wave_next = ~wave_reg;
        end
    end

    // Flags: overflow event and delayed match event
    logic ovf_event;
    assign ovf_event = timer_tick & (mode_phase ? (down_reg & count_reg == 8'h01) :
                       (mode_fast ? at_top : (count_reg == `CWM_MAX)));
    assign match_dly_next = timer_tick ? match_now : match_dly_reg;
    cwm_flag u_ovf
    (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .set_pulse(ovf_event),
        .clear_pulse(overflow_flag_clear),
        .flag(overflow_flag_w)
    );
    cwm_flag u_match
    (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .set_pulse(timer_tick & match_dly_reg),
        .clear_pulse(compare_a_match_flag_clear),
        .flag(match_flag_w)
    );

    // Port override: waveform drives pin when an action is selected
    assign pin_out_next = (output_action_select_a != `CWM_ACT_NONE) ? wave_next : port_data;
    assign pin_oe_next = pin_dir_out;

    // State registers
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count_reg <= `CWM_RST_COUNT;
            down_reg <= 1'b0;
            wave_reg <= 1'b0;
            match_dly_reg <= 1'b0;
            block_reg <= 1'b0;
            pin_out_reg <= 1'b0;
            pin_oe_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            down_reg <= down_next;
            wave_reg <= wave_next;
            match_dly_reg <= match_dly_next;
            block_reg <= block_next;
            pin_out_reg <= pin_out_next;
            pin_oe_reg <= pin_oe_next;
        end
    end

    // Outputs straight from flip-flops
    assign timer_count_value = count_reg;
    assign compare_a_value = cmp_active;
    assign overflow_flag = overflow_flag_w;
    assign compare_a_match_flag = match_flag_w;
    assign waveform_output_a = wave_reg;
    assign pin_out = pin_out_reg;
    assign pin_oe = pin_oe_reg;
endmodule

/* File: dv/cwm_timer_monitor.sv */
// Assertion checker for the counter waveform mode block
`timescale 1ns/100ps
`include "cwm_consts.svh"
module cwm_timer_monitor
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic timer_tick,
    input wire logic [2:0] waveform_mode_select,
    input wire logic [1:0] output_action_select_a,
    input wire logic compare_a_wr,
    input wire logic [7:0] compare_a_wr_data,
    input wire logic count_wr,
    input wire logic [7:0] count_wr_data,
    input wire logic overflow_flag_clear,
    input wire logic compare_a_match_flag_clear,
    input wire logic pin_dir_out,
    input wire logic port_data,
    input wire logic [7:0] timer_count_value,
    input wire logic [7:0] compare_a_value,
    input wire logic overflow_flag,
    input wire logic compare_a_match_flag,
    input wire logic waveform_output_a,
    input wire logic pin_out,
    input wire logic pin_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // CTC mode selected
    wire logic ctc = waveform_mode_select == `CWM_MODE_CTC;
    // Tick with the count on compare A and no count load
    wire logic hit = timer_tick && timer_count_value == compare_a_value && !count_wr;
    // Tick with the count at its maximum and no count load
    wire logic at_max = timer_tick && timer_count_value == `CWM_MAX && !count_wr;
    property p_ctc_clear;
        ctc && hit && !$past(count_wr) |=> timer_count_value == `CWM_BOTTOM;
    endproperty
    a_ctc_clear: assert property (p_ctc_clear) else $error("ctc count not cleared");
    property p_ctc_flag;
        ctc && hit && !$past(count_wr) ##1 timer_tick |=> compare_a_match_flag;
    endproperty
    a_ctc_flag: assert property (p_ctc_flag) else $error("match flag missing");
    property p_ctc_toggle;
        ctc && hit && !$past(count_wr) && output_action_select_a == `CWM_ACT_TOGGLE
            |=> waveform_output_a != $past(waveform_output_a);
    endproperty
    a_ctc_toggle: assert property (p_ctc_toggle) else $error("no toggle on match");
    property p_ctc_ovf;
        ctc && at_max |=> overflow_flag;
    endproperty
    a_ctc_ovf: assert property (p_ctc_ovf) else $error("ctc overflow flag missing");
    property p_hold;
        !timer_tick && !count_wr |=> $stable(timer_count_value);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved without tick");
    property p_fast_wrap;
        waveform_mode_select == `CWM_MODE_FAST_FF && at_max |=> timer_count_value == 8'h00;
    endproperty
    a_fast_wrap: assert property (p_fast_wrap) else $error("fast count not wrapped");
    property p_pc_top;
        waveform_mode_select == `CWM_MODE_PC_FF && at_max |=> timer_count_value == 8'hfe;
    endproperty
    a_pc_top: assert property (p_pc_top) else $error("top not held once");
    property p_pin_oe;
        $past(rst_b, 2) |-> pin_oe == $past(pin_dir_out);
    endproperty
    a_pin_oe: assert property (p_pin_oe) else $error("pin enable wrong");
    property p_pin_out;
        $past(rst_b, 2) |-> pin_out == ($past(output_action_select_a) != 2'h0 ?
            waveform_output_a : $past(port_data));
    endproperty
    a_pin_out: assert property (p_pin_out) else $error("pin value wrong");
    property p_no_action;
        ctc && output_action_select_a == `CWM_ACT_NONE |=> $stable(waveform_output_a);
    endproperty
    a_no_action: assert property (p_no_action) else $error("output moved");
endmodule
bind cwm_timer cwm_timer_monitor cwm_timer_monitor_inst (.*);

/* File: dv/cwm_timer_tb_top.sv */
// Self-checking bench for the counter waveform mode block
`timescale 1ns/100ps
`include "cwm_consts.svh"
module cwm_timer_tb_top;
    // Inputs, valued at time zero
    logic clk_sys = 1'b0, rst_b = 1'b0, timer_tick = 1'b1, compare_a_wr = 1'b0;
    logic count_wr = 1'b0, overflow_flag_clear = 1'b0, compare_a_match_flag_clear = 1'b0;
    logic pin_dir_out = 1'b1, port_data = 1'b0, prev;
    logic [2:0] waveform_mode_select = 3'h0;
    logic [1:0] output_action_select_a = 2'h0;
    logic [7:0] compare_a_wr_data = 8'h00, count_wr_data = 8'h00, held;
    logic [7:0] timer_count_value, compare_a_value;
    logic overflow_flag, compare_a_match_flag, waveform_output_a, pin_out, pin_oe;
    int mismatches = 0, checks = 0, high_n, rise_n;
    // Row: mode, action, compare, window, high cycles, rising edges
    typedef struct {logic [2:0] m; logic [1:0] a; logic [7:0] c; int w; int hi; int ri;} cwm_row_t;
    cwm_row_t rows [12] = '{'{3'h2, 2'h1, 8'h02, 60, 30, 10}, '{3'h2, 2'h1, 8'h00, 20, 10, 10},
        '{3'h3, 2'h2, 8'h3f, 512, 128, 2}, '{3'h3, 2'h3, 8'h3f, 512, 384, 2},
        '{3'h3, 2'h2, 8'h00, 512, 2, 2}, '{3'h3, 2'h2, 8'hff, 512, 0, 0},
        '{3'h7, 2'h1, 8'h09, 200, 100, 10}, '{3'h1, 2'h2, 8'h40, 1020, 256, 2},
        '{3'h1, 2'h3, 8'h40, 1020, 764, 2}, '{3'h1, 2'h2, 8'h00, 1020, 0, 0},
        '{3'h1, 2'h2, 8'hff, 1020, 1020, 0}, '{3'h5, 2'h1, 8'h09, 360, 180, 10}};
    cwm_timer cwm_timer_inst (.*);
    // System clock, 10 ns period
    always #5 clk_sys = ~clk_sys;
    // Let n edges pass, then step just past the last one
    task automatic step(int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            #1;
        end
    endtask
    // Compare and count
    task automatic check(logic [15:0] seen, logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Reset with a new mode and action
    task automatic start(logic [2:0] m, logic [1:0] a);
        rst_b = 1'b0;
        waveform_mode_select = m;
        output_action_select_a = a;
        step(2);
        rst_b = 1'b1;
        step(2);
    endtask
    // One-cycle compare write
    task automatic wr_cmp(logic [7:0] v);
        compare_a_wr_data = v;
        compare_a_wr = 1'b1;
        step(1);
        compare_a_wr = 1'b0;
    endtask
    // Wait for a count value, bounded
    task automatic wait_cnt(logic [7:0] v);
        for (int i = 0; i < 600 && timer_count_value !== v; i++)
            step(1);
        check(timer_count_value, v);
    endtask
    // Summary and verdict
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Hang guard
    initial
    begin
        #400000;
        mismatches++;
        give_verdict();
    end
    // Main sequence
    initial
    begin
        step(16);
        rst_b = 1'b1;
        foreach (rows[i])
        begin
            start(rows[i].m, rows[i].a);
            wr_cmp(rows[i].c);
            step(1100);
            high_n = 0;
            rise_n = 0;
            prev = waveform_output_a;
            repeat (rows[i].w)
            begin
                step(1);
                high_n += waveform_output_a;
                rise_n += waveform_output_a && !prev;
                prev = waveform_output_a;
            end
            check(high_n, rows[i].hi);
            check(rise_n, rows[i].ri);
            $display("row %0d done", i);
        end
        // Compare written below the count in CTC
        start(`CWM_MODE_CTC, `CWM_ACT_TOGGLE);
        wr_cmp(8'h80);
        count_wr_data = 8'h60;
        count_wr = 1'b1;
        step(1);
        count_wr = 1'b0;
        wr_cmp(8'h10);
        check(compare_a_value, 8'h10);
        // Drop the flag left by matches against the reset compare value
        compare_a_match_flag_clear = 1'b1;
        step(1);
        compare_a_match_flag_clear = 1'b0;
        wait_cnt(8'hff);
        check(compare_a_match_flag, 1'b0);
        step(1);
        check({timer_count_value, overflow_flag}, {8'h00, 1'b1});
        wait_cnt(8'h10);
        step(2);
        check(compare_a_match_flag, 1'b1);
        compare_a_match_flag_clear = 1'b1;
        step(1);
        compare_a_match_flag_clear = 1'b0;
        check(compare_a_match_flag, 1'b0);
        pin_dir_out = 1'b0;
        step(2);
        check(pin_oe, 1'b0);
        pin_dir_out = 1'b1;
        $display("missed match test done");
        // Stalled tick and no output action
        start(`CWM_MODE_CTC, `CWM_ACT_NONE);
        wr_cmp(8'h20);
        timer_tick = 1'b0;
        held = timer_count_value;
        port_data = 1'b1;
        step(20);
        check(timer_count_value, held);
        check(pin_out, 1'b1);
        timer_tick = 1'b1;
        wait_cnt(8'h20);
        step(2);
        check(waveform_output_a, 1'b0);
        $display("stall test done");
        // Fast PWM shadowed compare and overflow at top
        start(`CWM_MODE_FAST_FF, `CWM_ACT_CLEAR);
        wr_cmp(8'h55);
        check(compare_a_value, 8'h00);
        wait_cnt(8'hff);
        step(1);
        check({overflow_flag, compare_a_value}, {1'b1, 8'h55});
        $display("fast buffer test done");
        // Phase correct overflow at bottom
        start(`CWM_MODE_PC_FF, `CWM_ACT_CLEAR);
        wait_cnt(8'hff);
        overflow_flag_clear = 1'b1;
        step(1);
        overflow_flag_clear = 1'b0;
        wait_cnt(8'h00);
        check(overflow_flag, 1'b1);
        $display("phase overflow test done");
        // Phase correct: count moved above compare while rising misses the up match
        start(`CWM_MODE_PC_FF, `CWM_ACT_CLEAR);
        wr_cmp(8'h40);
        wait_cnt(8'hff);
        wait_cnt(8'h00);
        wait_cnt(8'h10);
        count_wr_data = 8'h80;
        count_wr = 1'b1;
        step(1);
        count_wr = 1'b0;
        wait_cnt(8'hff);
        check(waveform_output_a, 1'b1);
        step(1);
        check(waveform_output_a, 1'b0);
        wait_cnt(8'h3f);
        check(waveform_output_a, 1'b1);
        $display("phase symmetry test done");
        give_verdict();
    end
endmodule
